// *** design/dcr_pkg.sv ***
// Purpose: Constants for the deserializer configuration register bank
// Assumes: Three 8-bit registers at indices 0 to 2
// Notes: Operation summary follows
//
// Operation
// - Bit 7 of the first configuration register picks the low-frequency pixel-clock range.
// - Mode codes 00 and 01 give normal operation with the control filter off or on.
// - Mode codes 10 and 11 select one of two backward-compatible modes.
// - Bit 1 of the first configuration register enters sleep while keeping every register.
// - With bit 0 clear, the control pins set all but sleep and the bus address, whose source follows address register bit 7.
// - With bit 0 set, registers override the pins for everything but the bus address.
// - Bit 7 of the address register picks the strap or the register as address source.
// - Bits 6:0 hold the bus address; only 0x71, 0x72, 0x73 and 0x76 are valid.
// - Features bit 7 is the output enable, like the matching pin, under register control.
// - Features bit 6 selects the output state during sleep, like the matching pin.
// - Features bit 3 selects the output swing, 250 mV or 400 mV per side.
// - Lost link clock, outputs on, sleep state high, osc on: output clock from oscillator.
// - The first register resets to 00h and writing 01h hands control to the registers.
package dcr_pkg;
  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [1:0] DCR_OFS_CONFIG = 2'h0;
  localparam logic [1:0] DCR_OFS_ADDR = 2'h1;
  localparam logic [1:0] DCR_OFS_FEAT = 2'h2;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DCR_RST_CONFIG = 8'h00;
  localparam logic [7:0] DCR_RST_ADDR = 8'h70;
  localparam logic [7:0] DCR_RST_FEAT = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DCR_BIT_LFREQ = 7;
  localparam int DCR_BIT_MODE_LO = 2;
  localparam int DCR_BIT_SLEEP = 1;
  localparam int DCR_BIT_REGCTL = 0;
  localparam int DCR_BIT_ADDRSRC = 7;
  localparam int DCR_BIT_OEN = 7;
  localparam int DCR_BIT_OSS = 6;
  localparam int DCR_BIT_SWING = 3;
  // ------------------------------------------------------------
  // Valid bus addresses and oscillator codes
  // ------------------------------------------------------------
  localparam logic [6:0] DCR_ADDR_A = 7'h71;
  localparam logic [6:0] DCR_ADDR_B = 7'h72;
  localparam logic [6:0] DCR_ADDR_C = 7'h73;
  localparam logic [6:0] DCR_ADDR_D = 7'h76;
  localparam logic [2:0] DCR_OSC_OFF = 3'h0;
  localparam logic [2:0] DCR_OSC_RSVD = 3'h1;
  // Mode codes
  typedef enum logic [1:0] {
    DCR_MODE_NORM = 2'h0,
    DCR_MODE_FILT = 2'h1,
    DCR_MODE_COMPAT_A = 2'h2,
    DCR_MODE_COMPAT_B = 2'h3
  } dcr_mode_t;
endpackage

// *** design/dcr_config_regs.sv ***
// Purpose: Configuration register bank with pin/register selection
// Assumes: Bus protocol engine outside delivers index, data, write and read strobes
//          Pin inputs are static straps or slow controls
// Notes: All outputs registered; strap and pin inputs pass two flip-flops
//        Pin changes reach the outputs three enabled edges after they occur
`timescale 1ns/1ps
`default_nettype none
module dcr_config_regs (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Register access from the bus engine
  input wire logic [1:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // Control and strap pins
  input wire logic low_freq_range_pin,
  input wire logic [1:0] mode_pin,
  input wire logic output_drive_enable_pin,
  input wire logic output_sleep_state_pin,
  input wire logic swing_level_pin,
  input wire logic [2:0] fallback_osc_pin,
  input wire logic [1:0] address_strap_pin,
  // Link status
  input wire logic link_clock_lost,
  // Effective configuration
  output logic low_freq_range_select_ff,
  output logic [1:0] mode_select_ff,
  output logic filter_enable_ff,
  output logic compat_mode_ff,
  output logic sleep_active_ff,
  output logic output_drive_enable_ff,
  output logic output_sleep_state_select_ff,
  output logic swing_level_select_ff,
  output logic [2:0] fallback_osc_select_ff,
  output logic [6:0] bus_address_setting_ff,
  output logic bus_address_invalid_ff,
  output logic lvds_clock_from_osc_ff
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Register contents, reserved bits included
  logic [7:0] config_one_ff;
  logic [7:0] addr_setup_ff;
  logic [7:0] features_one_ff;
  // Synchroniser stages for pins, link status and strap
  logic [8:0] pin_s1_ff;
  logic [8:0] pin_s2_ff;
  logic lost_s1_ff;
  logic lost_s2_ff;
  logic [1:0] strap_s1_ff;
  logic [1:0] strap_s2_ff;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Two-stage synchronisers; stage one feeds stage two only
  // Sampling stops while disabled, so a frozen bank also freezes its view
  // of the pins; the extra latency is harmless for static straps
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 9'h000;
      pin_s2_ff <= 9'h000;
      lost_s1_ff <= 1'b0;
      lost_s2_ff <= 1'b0;
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
    end else if (clk_en) begin
      pin_s1_ff <= {low_freq_range_pin, mode_pin, output_drive_enable_pin,
                    output_sleep_state_pin, swing_level_pin, fallback_osc_pin};
      pin_s2_ff <= pin_s1_ff;
      lost_s1_ff <= link_clock_lost;
      lost_s2_ff <= lost_s1_ff;
      strap_s1_ff <= address_strap_pin;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  // Register writes; reserved bits stored as written
  // An index of 3 lands nowhere; the write is dropped without a flag
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      config_one_ff <= dcr_pkg::DCR_RST_CONFIG;
      addr_setup_ff <= dcr_pkg::DCR_RST_ADDR;
      features_one_ff <= dcr_pkg::DCR_RST_FEAT;
    end else if (clk_en && reg_wr) begin
      // Sleep leaves writes alive so software can wake the part
      case (reg_index)
        dcr_pkg::DCR_OFS_CONFIG: config_one_ff <= reg_wdata;
        dcr_pkg::DCR_OFS_ADDR: addr_setup_ff <= reg_wdata;
        dcr_pkg::DCR_OFS_FEAT: features_one_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Read port; unmapped index reads zero
  // A read beside a write to the same index returns the old contents,
  // since both act on one edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        case (reg_index)
          dcr_pkg::DCR_OFS_CONFIG: reg_rdata_ff <= config_one_ff;
          dcr_pkg::DCR_OFS_ADDR: reg_rdata_ff <= addr_setup_ff;
          dcr_pkg::DCR_OFS_FEAT: reg_rdata_ff <= features_one_ff;
          default: reg_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic reg_ctl;
  logic nxt_lfreq;
  logic [1:0] nxt_mode;
  logic nxt_oen;
  logic nxt_oss;
  logic nxt_swing;
  logic [2:0] nxt_osc;
  logic [6:0] nxt_addr;
  logic [6:0] strap_addr;

  assign reg_ctl = config_one_ff[dcr_pkg::DCR_BIT_REGCTL];

  // Strap decode to one of the four valid addresses
  // Every strap code maps to a valid address, so the strap alone never flags
  always_comb begin
    case (strap_s2_ff)
      2'h0: strap_addr = dcr_pkg::DCR_ADDR_A;
      2'h1: strap_addr = dcr_pkg::DCR_ADDR_B;
      2'h2: strap_addr = dcr_pkg::DCR_ADDR_C;
      default: strap_addr = dcr_pkg::DCR_ADDR_D;
    endcase
  end

  // Pins rule unless register control is set
  // Sleep has no pin, so it stays outside this choice
  always_comb begin
    if (reg_ctl) begin
      nxt_lfreq = config_one_ff[dcr_pkg::DCR_BIT_LFREQ];
      nxt_mode = config_one_ff[dcr_pkg::DCR_BIT_MODE_LO +: 2];
      nxt_oen = features_one_ff[dcr_pkg::DCR_BIT_OEN];
      nxt_oss = features_one_ff[dcr_pkg::DCR_BIT_OSS];
      nxt_swing = features_one_ff[dcr_pkg::DCR_BIT_SWING];
      nxt_osc = features_one_ff[2:0];
    end else begin
      nxt_lfreq = pin_s2_ff[8];
      nxt_mode = pin_s2_ff[7:6];
      nxt_oen = pin_s2_ff[5];
      nxt_oss = pin_s2_ff[4];
      nxt_swing = pin_s2_ff[3];
      nxt_osc = pin_s2_ff[2:0];
    end
    // Address ignores register control; only its own source bit matters
    if (addr_setup_ff[dcr_pkg::DCR_BIT_ADDRSRC]) begin
      nxt_addr = addr_setup_ff[6:0];
    end else begin
      nxt_addr = strap_addr;
    end
  end

  // ------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------
  // Effective configuration outputs
  // One edge after the choice keeps every output straight from a flop
  // Reset shows the open-strap address until the first enabled edge, then 0x71 until the strap sync settles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_freq_range_select_ff <= 1'b0;
      mode_select_ff <= 2'h0;
      filter_enable_ff <= 1'b0;
      compat_mode_ff <= 1'b0;
      sleep_active_ff <= 1'b0;
      output_drive_enable_ff <= 1'b0;
      output_sleep_state_select_ff <= 1'b0;
      swing_level_select_ff <= 1'b0;
      fallback_osc_select_ff <= 3'h0;
      bus_address_setting_ff <= dcr_pkg::DCR_ADDR_D;
      bus_address_invalid_ff <= 1'b0;
      lvds_clock_from_osc_ff <= 1'b0;
    end else if (clk_en) begin
      low_freq_range_select_ff <= nxt_lfreq;
      mode_select_ff <= nxt_mode;
      filter_enable_ff <= (nxt_mode == dcr_pkg::DCR_MODE_FILT);
      compat_mode_ff <= nxt_mode[1];
      sleep_active_ff <= config_one_ff[dcr_pkg::DCR_BIT_SLEEP];
      output_drive_enable_ff <= nxt_oen;
      output_sleep_state_select_ff <= nxt_oss;
      swing_level_select_ff <= nxt_swing;
      // Reserved code 001 treated as off
      fallback_osc_select_ff <= (nxt_osc == dcr_pkg::DCR_OSC_RSVD) ?
                                dcr_pkg::DCR_OSC_OFF : nxt_osc;
      bus_address_setting_ff <= nxt_addr;
      bus_address_invalid_ff <= !(nxt_addr == dcr_pkg::DCR_ADDR_A ||
                                  nxt_addr == dcr_pkg::DCR_ADDR_B ||
                                  nxt_addr == dcr_pkg::DCR_ADDR_C ||
                                  nxt_addr == dcr_pkg::DCR_ADDR_D);
      // Reserved oscillator code never starts the fallback clock;
      // pin or register values feed it alike
      lvds_clock_from_osc_ff <= lost_s2_ff && nxt_oen && nxt_oss &&
                                (nxt_osc != dcr_pkg::DCR_OSC_OFF) &&
                                (nxt_osc != dcr_pkg::DCR_OSC_RSVD);
    end
  end
endmodule // dcr_config_regs
`default_nettype wire

// *** testbench/dcr_config_regs_properties.sv ***
// Purpose: Port properties of the config bank
// Assumes: One clock, async low reset
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module dcr_config_regs_properties (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid_ff,
  input wire logic [1:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  // Effective settings
  input wire logic [1:0] mode_select_ff,
  input wire logic low_freq_range_select_ff,
  input wire logic filter_enable_ff,
  input wire logic compat_mode_ff,
  input wire logic sleep_active_ff,
  input wire logic bus_address_invalid_ff,
  input wire logic [6:0] bus_address_setting_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Write, then a quiet cycle so outputs can settle
  sequence s_wr(i);
    clk_en && reg_wr && reg_index == i ##1 clk_en && !reg_wr;
  endsequence
  a_read_valid_pulse: assert property (clk_en |=> reg_rvalid_ff == $past(reg_rd))
    else $error("read valid wrong");
  a_unmapped_read_zero: assert property (clk_en && reg_rd && reg_index == 2'h3
    |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  a_write_read_back: assert property (clk_en && reg_wr && reg_index != 2'h3 ##1
    clk_en && !reg_wr ##1 clk_en && reg_rd && !reg_wr && reg_index == $past(reg_index, 2)
    |=> reg_rdata_ff == $past(reg_wdata, 3)) else $error("read back wrong");
  a_filter_mode_decode: assert property (filter_enable_ff == (mode_select_ff == 2'h1))
    else $error("filter decode wrong");
  a_compat_mode_decode: assert property (compat_mode_ff == mode_select_ff[1])
    else $error("compat decode wrong");
  a_address_valid_set: assert property (bus_address_invalid_ff !=
    (bus_address_setting_ff inside {7'h71, 7'h72, 7'h73, 7'h76})) else $error("address flag wrong");
  a_sleep_from_write: assert property (s_wr(2'h0)
    |=> sleep_active_ff == $past(reg_wdata[1], 2)) else $error("sleep wrong");
  a_lfreq_under_regs: assert property (s_wr(2'h0) |=> $past(reg_wdata[0], 2) ->
    low_freq_range_select_ff == $past(reg_wdata[7], 2)) else $error("range wrong");
  a_mode_under_regs: assert property (s_wr(2'h0) |=> $past(reg_wdata[0], 2) ->
    mode_select_ff == $past(reg_wdata[3:2], 2)) else $error("mode wrong");
  a_addr_from_reg: assert property (s_wr(2'h1) |=> $past(reg_wdata[7], 2) ->
    bus_address_setting_ff == $past(reg_wdata[6:0], 2)) else $error("address wrong");
  c_addr_write: cover property (s_wr(2'h1));
  c_read_asleep: cover property (sleep_active_ff && reg_rvalid_ff);
  c_bad_address: cover property (bus_address_invalid_ff);
endmodule // dcr_config_regs_properties
bind dcr_config_regs dcr_config_regs_properties chk (
  .clock(clock), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid_ff(reg_rvalid_ff), .reg_index(reg_index), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .mode_select_ff(mode_select_ff),
  .low_freq_range_select_ff(low_freq_range_select_ff), .filter_enable_ff(filter_enable_ff),
  .compat_mode_ff(compat_mode_ff), .sleep_active_ff(sleep_active_ff),
  .bus_address_invalid_ff(bus_address_invalid_ff),
  .bus_address_setting_ff(bus_address_setting_ff)
);
`default_nettype wire

// *** testbench/dcr_host_model.sv ***
// Purpose: Host stand-in issuing register accesses
// Assumes: Strobes change just after rising edges
// Notes: One strobe cycle per access
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
  // Clock
  input wire logic clock,
  // Register access
  output logic [1:0] reg_index,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  // Idle bus from time zero
  initial begin
    reg_index <= 2'h0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  end
  task automatic host_write(input logic [1:0] i, input logic [7:0] d);
    @(posedge clock);
    reg_index <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Data taken at the edge where valid is sampled; no valid gives unknown data
  task automatic host_read(input logic [1:0] i, output logic [7:0] d);
    @(posedge clock);
    reg_index <= i;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rvalid_ff ? reg_rdata_ff : 8'hxx;
  endtask
endmodule // dcr_host_model
`default_nettype wire

// *** testbench/deser_config_registers_test.sv ***
// Purpose: Self-checking bench of the config bank
// Assumes: Host model makes accesses, pins set here
// Notes: Table for read-back, hand tests after
`timescale 1ns/1ps
`default_nettype none
module deser_config_registers_test;
  logic clock, nrst, clk_en, reg_wr, reg_rd, reg_rvalid_ff, low_freq_range_pin;
  logic output_drive_enable_pin, output_sleep_state_pin, swing_level_pin, link_clock_lost;
  logic low_freq_range_select_ff, filter_enable_ff, compat_mode_ff, sleep_active_ff;
  logic output_drive_enable_ff, output_sleep_state_select_ff, swing_level_select_ff;
  logic lvds_clock_from_osc_ff, bus_address_invalid_ff;
  logic [1:0] reg_index, mode_pin, address_strap_pin, mode_select_ff;
  logic [2:0] fallback_osc_pin, fallback_osc_select_ff;
  logic [6:0] bus_address_setting_ff;
  logic [7:0] reg_wdata, reg_rdata_ff, rd;
  logic [15:0] eff;
  logic [17:0] rows [4] = '{{2'h0, 8'ha5, 8'ha5}, {2'h1, 8'h71, 8'h71},
    {2'h2, 8'h3c, 8'h3c}, {2'h3, 8'h5a, 8'h00}};
  int n_fail = 0;
  int checks_done = 0;
  // Settings packed so one compare covers them
  assign eff = {2'h0, low_freq_range_select_ff, mode_select_ff, filter_enable_ff,
    compat_mode_ff, sleep_active_ff, output_drive_enable_ff, output_sleep_state_select_ff,
    swing_level_select_ff, fallback_osc_select_ff, lvds_clock_from_osc_ff, bus_address_invalid_ff};
  dcr_config_regs uut (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .low_freq_range_pin(low_freq_range_pin),
    .mode_pin(mode_pin), .output_drive_enable_pin(output_drive_enable_pin),
    .output_sleep_state_pin(output_sleep_state_pin), .swing_level_pin(swing_level_pin),
    .fallback_osc_pin(fallback_osc_pin), .address_strap_pin(address_strap_pin),
    .link_clock_lost(link_clock_lost), .low_freq_range_select_ff(low_freq_range_select_ff),
    .mode_select_ff(mode_select_ff), .filter_enable_ff(filter_enable_ff),
    .compat_mode_ff(compat_mode_ff), .sleep_active_ff(sleep_active_ff),
    .output_drive_enable_ff(output_drive_enable_ff),
    .output_sleep_state_select_ff(output_sleep_state_select_ff),
    .swing_level_select_ff(swing_level_select_ff),
    .fallback_osc_select_ff(fallback_osc_select_ff),
    .bus_address_setting_ff(bus_address_setting_ff),
    .bus_address_invalid_ff(bus_address_invalid_ff),
    .lvds_clock_from_osc_ff(lvds_clock_from_osc_ff)
  );
  dcr_host_model host (
    .clock(clock), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_settle(input logic [1:0] i, input logic [7:0] d);
    host.host_write(i, d);
    repeat (3) @(posedge clock);
  endtask
  task automatic chk_defaults;
    logic [7:0] dflt [3] = '{8'h00, 8'h70, 8'h00};
    for (int k = 0; k < 3; k++) begin
      host.host_read(k[1:0], rd);
      chk({8'h0, rd}, {8'h0, dflt[k]});
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    n_fail++;
    results;
  end
  initial begin
    nrst <= 1'b0;
    clk_en <= 1'b1;
    {low_freq_range_pin, mode_pin, output_drive_enable_pin, output_sleep_state_pin,
      swing_level_pin, fallback_osc_pin, address_strap_pin, link_clock_lost} <= 12'hbd3;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    chk_defaults;
    repeat (3) @(posedge clock);
    chk(eff, 16'h2cea);
    chk({9'h0, bus_address_setting_ff}, 16'h0072);
    $display("pins done");
    foreach (rows[k]) begin
      host.host_write(rows[k][17:16], rows[k][15:8]);
      host.host_read(rows[k][17:16], rd);
      chk({8'h0, rd}, {8'h0, rows[k][7:0]});
    end
    wr_settle(2'h0, 8'h0f);
    wr_settle(2'h1, 8'hf3);
    wr_settle(2'h2, 8'h00);
    chk(eff, 16'h1b00);
    chk({9'h0, bus_address_setting_ff}, 16'h0073);
    host.host_read(2'h1, rd);
    chk({8'h0, rd}, 16'h00f3);
    wr_settle(2'h2, 8'hca);
    chk(eff, 16'h1bea);
    wr_settle(2'h2, 8'hc9);
    chk(eff, 16'h1be0);
    wr_settle(2'h1, 8'hf4);
    chk({bus_address_setting_ff, eff[8:0]}, 16'he9e1);
    wr_settle(2'h1, 8'h73);
    chk({9'h0, bus_address_setting_ff}, 16'h0072);
    for (int m = 0; m < 4; m++) begin
      wr_settle(2'h0, {4'h0, m[1:0], 2'h1});
      chk({12'h0, mode_select_ff, filter_enable_ff, compat_mode_ff},
        {12'h0, m[1:0], m == 1, m > 1});
    end
    $display("overrides done");
    // Write while frozen must not land
    clk_en <= 1'b0;
    host.host_write(2'h2, 8'hff);
    clk_en <= 1'b1;
    host.host_read(2'h2, rd);
    chk({8'h0, rd}, 16'h00c9);
    $display("freeze done");
    nrst <= 1'b0;
    {low_freq_range_pin, mode_pin, output_drive_enable_pin, output_sleep_state_pin,
      swing_level_pin, fallback_osc_pin, address_strap_pin, link_clock_lost} <= 12'h59e;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    chk_defaults;
    chk(eff, 16'h12cc);
    chk({9'h0, bus_address_setting_ff}, 16'h0076);
    $display("reset done");
    results;
  end
endmodule // deser_config_registers_test
`default_nettype wire
